// ===== design/bsc_boot_config.sv
//
// Operation
// - after reset the transport strap picks UART at 0 and USB at 1.
// - UART with frequency strap 0: the pull-up pin picks 13 or 26 MHz.
// - UART with frequency strap 1: stored config sets it, else 32 MHz.
// - with USB the frequency strap is ignored and 32 MHz is used.
// - the radio direction output has programmable polarity, low is transmit while the polarity bit is clear.
// - the regulator pin is plain I/O until its function bit is set.
// - in ROM mode D4..D8 are I/O; A17, A16 and write strobe serve EEPROM.
// - memory select, read and write strobes are active low.
// - the pull-up pin is an output switching the USB D+ pull-up.
// - reset clears the registers but sets strobes and txrx_dir high and ref_mhz to 32 MHz; wake lines run to and from the host.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module bsc_boot_config import bsc_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dedicated prog_io pins 0..2
    input wire logic [2:0] prog_io_in,
    output logic [2:0] prog_io_out,
    output logic [2:0] prog_io_oe,
    // shared regulator enable pin, also prog_io 8
    input wire logic ext_regulator_enable_in,
    output logic ext_regulator_enable_out,
    output logic ext_regulator_enable_oe,
    // usb d+ pull-up control pin
    input wire logic dplus_pullup_ctl_in,
    output logic dplus_pullup_ctl_out,
    output logic dplus_pullup_ctl_oe,
    // radio and wake lines
    input wire logic radio_tx,
    output logic txrx_dir,
    input wire logic wake_from_host,
    output logic wake_to_host,
    // stored configuration
    input wire logic stored_config_valid,
    input wire logic [5:0] stored_config_mhz,
    // memory controller side
    input wire logic [18:0] mc_addr,
    input wire logic [15:0] mc_dout,
    input wire logic mc_doe,
    output logic [15:0] mc_din,
    input wire logic mc_cs,
    input wire logic mc_rd,
    input wire logic mc_wr,
    // external memory pins
    output logic [18:0] mem_addr,
    input wire logic [15:0] mem_data_in,
    output logic [15:0] mem_data_out,
    output logic [15:0] mem_data_oe,
    output logic mem_select_low,
    output logic mem_read_low,
    output logic mem_write_low,
    // boot status
    output logic usb_transport,
    output logic [5:0] ref_mhz,
    output logic rom_boot,
    output logic config_done
);
    // ======================================================
    // declarations
    logic cap_ff;
    logic usb_ff, fstrap_ff, pstrap_ff;
    logic st_valid_ff;
    logic [5:0] st_mhz_ff;
    logic [CTL_W-1:0] ctl_ff;
    logic [8:0] io_out_ff, io_oe_ff, io_in;
    logic [EE_W-1:0] ee_ff;
    logic [31:0] nxt_prdata;
    logic wake_in_ff;
    logic probe_done, probe_rom, d9_out, d9_oe;
    logic apb_wr, apb_setup, hit;
    logic [15:0] nxt_d_out, nxt_d_oe;
    logic [18:0] nxt_addr;

    // ======================================================
    // strap capture, once per reset
    // first edge after release samples the straps; the pins are
    // not driven before then so the board levels are read clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_ff <= 1'b0;
            usb_ff <= 1'b0;
            fstrap_ff <= 1'b0;
            pstrap_ff <= 1'b0;
            st_valid_ff <= 1'b0;
            st_mhz_ff <= 6'h00;
        end else if (!cap_ff) begin
            cap_ff <= 1'b1;
            usb_ff <= prog_io_in[2];
            fstrap_ff <= prog_io_in[1];
            pstrap_ff <= dplus_pullup_ctl_in;
            st_valid_ff <= stored_config_valid;
            st_mhz_ff <= stored_config_mhz;
        end
    end

    // resolved frequency, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_mhz <= MHZ_32;
        end else begin
            ref_mhz <= bsc_ref_pick(usb_ff, fstrap_ff, pstrap_ff,
                st_valid_ff, st_mhz_ff);
        end
    end

    assign usb_transport = usb_ff;

    // ======================================================
    // rom link probe starts once straps are held
    bsc_rom_probe u_probe (
        .pclk(pclk),
        .presetn(presetn),
        .start(cap_ff),
        .done(probe_done),
        .rom_sel(probe_rom),
        .d9_out(d9_out),
        .d9_oe(d9_oe),
        .d10_in(mem_data_in[10])
    );
    assign rom_boot = probe_done & probe_rom;
    assign config_done = probe_done;

    // ======================================================
    // apb slave: zero wait states, read data set up in the
    // setup phase so it comes from a register
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == OFS_CTRL) || (paddr == OFS_IO_OUT) ||
        (paddr == OFS_IO_OE) || (paddr == OFS_EEPROM) ||
        (paddr == OFS_STATUS) || (paddr == OFS_IO_IN);
    // unmapped addresses answer with an error and no effect
    assign pslverr = psel & penable & ~hit;

    // writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= CTL_RESET;
            io_out_ff <= 9'h000;
            io_oe_ff <= 9'h000;
            ee_ff <= EE_RESET;
        end else if (apb_wr) begin
            unique case (paddr)
                OFS_CTRL: ctl_ff <= pwdata[CTL_W-1:0];
                OFS_IO_OUT: io_out_ff <= pwdata[8:0];
                OFS_IO_OE: io_oe_ff <= pwdata[8:0];
                OFS_EEPROM: ee_ff <= pwdata[EE_W-1:0];
                default: ;
            endcase
        end
    end

    // read mux
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: nxt_prdata[CTL_W-1:0] = ctl_ff;
            OFS_IO_OUT: nxt_prdata[8:0] = io_out_ff;
            OFS_IO_OE: nxt_prdata[8:0] = io_oe_ff;
            OFS_EEPROM: nxt_prdata[EE_W-1:0] = ee_ff;
            OFS_STATUS: begin
                nxt_prdata[ST_USB] = usb_ff;
                nxt_prdata[ST_FSTRAP] = fstrap_ff;
                nxt_prdata[ST_PSTRAP] = pstrap_ff;
                nxt_prdata[ST_ROM] = rom_boot;
                nxt_prdata[ST_DONE] = probe_done;
                nxt_prdata[ST_WAKE_IN] = wake_in_ff;
                nxt_prdata[ST_MHZ_LSB +: 6] = ref_mhz;
            end
            OFS_IO_IN: nxt_prdata[8:0] = io_in;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= nxt_prdata;
        end
    end

    // ======================================================
    // prog_io input view: data lines carry 3..7 only in rom mode
    assign io_in = {ext_regulator_enable_in,
        rom_boot ? mem_data_in[7:4] : 4'h0,
        rom_boot ? mem_data_in[8] : 1'b0,
        prog_io_in};

    // ======================================================
    // dedicated pins, regulator pin, pull-up pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_io_out <= 3'h0;
            prog_io_oe <= 3'h0;
            ext_regulator_enable_out <= 1'b0;
            ext_regulator_enable_oe <= 1'b0;
            dplus_pullup_ctl_out <= 1'b0;
            dplus_pullup_ctl_oe <= 1'b0;
        end else begin
            // hold off until straps are in, so a strap is never
            // overdriven while it is being sampled
            prog_io_out <= io_out_ff[2:0];
            prog_io_oe <= cap_ff ? io_oe_ff[2:0] : 3'h0;
            if (ctl_ff[CTL_REG_FUNC]) begin
                ext_regulator_enable_out <= ctl_ff[CTL_REG_ON] ^
                    ctl_ff[CTL_REG_POL_LOW];
                ext_regulator_enable_oe <= 1'b1;
            end else begin
                ext_regulator_enable_out <= io_out_ff[8];
                ext_regulator_enable_oe <= io_oe_ff[8];
            end
            dplus_pullup_ctl_out <= ctl_ff[CTL_PULLUP_ON];
            dplus_pullup_ctl_oe <= cap_ff;
        end
    end

    // radio direction and wake lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txrx_dir <= 1'b1;
            wake_to_host <= 1'b0;
            wake_in_ff <= 1'b0;
        end else begin
            // polarity bit clear: low means transmit
            txrx_dir <= ~radio_tx ^ ctl_ff[CTL_DIR_POL];
            wake_to_host <= ctl_ff[CTL_WAKE_HOST];
            wake_in_ff <= wake_from_host;
        end
    end

    // ======================================================
    // memory pin mux: rom mode lends data and strobe pins away
    always_comb begin
        nxt_addr = mc_addr;
        nxt_d_out = mc_dout;
        nxt_d_oe = {16{mc_doe & probe_done}};
        if (rom_boot) begin
            nxt_addr[17] = ee_ff[EE_SCL];
            nxt_addr[16] = ee_ff[EE_SDA];
            nxt_d_out[7:4] = io_out_ff[7:4];
            nxt_d_oe[7:4] = io_oe_ff[7:4];
            nxt_d_out[8] = io_out_ff[3];
            nxt_d_oe[8] = io_oe_ff[3];
        end
        if (!probe_done) begin
            // only the probe drives while the link is tested
            nxt_d_out[9] = d9_out;
            nxt_d_oe[9] = d9_oe;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr <= 19'h00000;
            mem_data_out <= 16'h0000;
            mem_data_oe <= 16'h0000;
            mem_select_low <= 1'b1;
            mem_read_low <= 1'b1;
            mem_write_low <= 1'b1;
            mc_din <= 16'h0000;
        end else begin
            mem_addr <= nxt_addr;
            mem_data_out <= nxt_d_out;
            mem_data_oe <= nxt_d_oe;
            mem_select_low <= ~(mc_cs & ~rom_boot);
            mem_read_low <= ~(mc_rd & ~rom_boot);
            // write strobe doubles as eeprom write protect
            mem_write_low <= rom_boot ? ee_ff[EE_WP] : ~mc_wr;
            mc_din <= mem_data_in;
        end
    end

    // ======================================================
    // checks
    property p_strap_hold;
        @(posedge pclk) disable iff (!presetn)
        cap_ff ##1 1'b1 |-> $stable(usb_ff) && $stable(pstrap_ff)
            && $stable(fstrap_ff);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap changed after capture");

    property p_usb_sel;
        @(posedge pclk) disable iff (!presetn)
        !cap_ff |=> usb_ff == $past(prog_io_in[2]);
    endproperty
    a_usb_sel: assert property (p_usb_sel)
        else $error("transport strap not captured");

    property p_usb_32;
        @(posedge pclk) disable iff (!presetn)
        cap_ff && usb_ff |=> ref_mhz == MHZ_32;
    endproperty
    a_usb_32: assert property (p_usb_32)
        else $error("usb transport not at 32 MHz");

    property p_uart_pin;
        @(posedge pclk) disable iff (!presetn)
        cap_ff && !usb_ff && !fstrap_ff |=>
            ref_mhz == (pstrap_ff ? MHZ_26 : MHZ_13);
    endproperty
    a_uart_pin: assert property (p_uart_pin)
        else $error("uart pin frequency wrong");

    property p_uart_stored;
        @(posedge pclk) disable iff (!presetn)
        cap_ff && !usb_ff && fstrap_ff |=> ref_mhz ==
            ($past(st_valid_ff) ? $past(st_mhz_ff) : MHZ_32);
    endproperty
    a_uart_stored: assert property (p_uart_stored)
        else $error("stored frequency wrong");

    // the edge that releases reset still loads the reset level
    property p_dir;
        @(posedge pclk) disable iff (!presetn)
        presetn && !ctl_ff[CTL_DIR_POL] && radio_tx |=> !txrx_dir;
    endproperty
    a_dir: assert property (p_dir)
        else $error("transmit not shown low");

    property p_reg_gpio;
        @(posedge pclk) disable iff (!presetn)
        !ctl_ff[CTL_REG_FUNC] |=>
            ext_regulator_enable_oe == $past(io_oe_ff[8]);
    endproperty
    a_reg_gpio: assert property (p_reg_gpio)
        else $error("regulator pin left gpio mode");

    property p_rom_io;
        @(posedge pclk) disable iff (!presetn)
        rom_boot |=> mem_data_out[8] == $past(io_out_ff[3]) &&
            mem_addr[17] == $past(ee_ff[EE_SCL]);
    endproperty
    a_rom_io: assert property (p_rom_io)
        else $error("rom pin reuse wrong");

    property p_strobe;
        @(posedge pclk) disable iff (!presetn)
        mc_cs && !rom_boot |=> !mem_select_low;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("select strobe not low");

    property p_pullup;
        @(posedge pclk) disable iff (!presetn)
        cap_ff |=> dplus_pullup_ctl_oe &&
            dplus_pullup_ctl_out == $past(ctl_ff[CTL_PULLUP_ON]);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up pin wrong");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> wake_to_host == $past(ctl_ff[CTL_WAKE_HOST]);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake output wrong");
endmodule : bsc_boot_config

// ===== design/bsc_pkg.sv
package bsc_pkg;
    // ======================================================
    // register map (byte addresses on the APB bus)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IO_OUT = 8'h04;
    localparam logic [7:0] OFS_IO_OE = 8'h08;
    localparam logic [7:0] OFS_EEPROM = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IO_IN = 8'h14;

    // ======================================================
    // control register fields
    localparam int CTL_DIR_POL = 0;
    localparam int CTL_REG_FUNC = 1;
    localparam int CTL_REG_POL_LOW = 2;
    localparam int CTL_REG_ON = 3;
    localparam int CTL_PULLUP_ON = 4;
    localparam int CTL_WAKE_HOST = 5;
    localparam int CTL_W = 6;
    localparam logic [5:0] CTL_RESET = 6'h00;

    // eeprom register fields
    localparam int EE_SCL = 0;
    localparam int EE_SDA = 1;
    localparam int EE_WP = 2;
    localparam int EE_W = 3;
    localparam logic [2:0] EE_RESET = 3'h0;

    // status register fields
    localparam int ST_USB = 0;
    localparam int ST_FSTRAP = 1;
    localparam int ST_PSTRAP = 2;
    localparam int ST_ROM = 3;
    localparam int ST_DONE = 4;
    localparam int ST_WAKE_IN = 5;
    localparam int ST_MHZ_LSB = 8;

    // ======================================================
    // reference frequencies in MHz
    localparam logic [5:0] MHZ_13 = 6'h0D;
    localparam logic [5:0] MHZ_26 = 6'h1A;
    localparam logic [5:0] MHZ_32 = 6'h20;

    // ======================================================
    // rom link probe timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROBE_SETTLE_NS = 16;
    localparam int PROBE_CYC =
        (PROBE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PROBE_CNT = 4'(PROBE_CYC);

    typedef enum logic [3:0] {
        PR_IDLE = 4'b0001,
        PR_HIGH = 4'b0010,
        PR_LOW = 4'b0100,
        PR_DONE = 4'b1000
    } bsc_probe_e;

    // ======================================================
    // reference frequency chosen from the captured straps
    function automatic logic [5:0] bsc_ref_pick(
        input logic usb, input logic fstrap, input logic pstrap,
        input logic st_valid, input logic [5:0] st_mhz);
        if (usb) begin
            bsc_ref_pick = MHZ_32;
        end else if (fstrap) begin
            bsc_ref_pick = st_valid ? st_mhz : MHZ_32;
        end else begin
            bsc_ref_pick = pstrap ? MHZ_26 : MHZ_13;
        end
    endfunction : bsc_ref_pick
endpackage : bsc_pkg

// ===== design/bsc_rom_probe.sv
`timescale 1ns/1ps
// drives data line 9 high then low and watches data line 10;
// only a board link between them follows both levels
module bsc_rom_probe import bsc_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    output logic done,
    output logic rom_sel,
    // probe pins
    output logic d9_out,
    output logic d9_oe,
    input wire logic d10_in
);
    bsc_probe_e state_ff;
    logic [3:0] cnt_ff;
    logic saw_hi_ff;

    // ======================================================
    // probe sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= PR_IDLE;
            cnt_ff <= 4'h0;
            saw_hi_ff <= 1'b0;
            rom_sel <= 1'b0;
        end else begin
            unique case (state_ff)
                PR_IDLE: begin
                    cnt_ff <= PROBE_CNT;
                    if (start) state_ff <= PR_HIGH;
                end
                PR_HIGH: begin
                    if (cnt_ff == 4'h1) begin
                        saw_hi_ff <= d10_in;
                        cnt_ff <= PROBE_CNT;
                        state_ff <= PR_LOW;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                PR_LOW: begin
                    if (cnt_ff == 4'h1) begin
                        // pull-down alone would fail the high step
                        rom_sel <= saw_hi_ff & ~d10_in;
                        state_ff <= PR_DONE;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                PR_DONE: state_ff <= PR_DONE;
                default: state_ff <= PR_IDLE;
            endcase
        end
    end

    // pin drive follows the state
    assign d9_oe = (state_ff == PR_HIGH) || (state_ff == PR_LOW);
    assign d9_out = (state_ff == PR_HIGH);
    assign done = (state_ff == PR_DONE);
endmodule : bsc_rom_probe

// ===== bench/bsc_board_model.sv
`timescale 1ns/1ps
// board side: strap resistors, data pull-downs, optional rom link
module bsc_board_model (
    // strap settings chosen by the bench
    input wire logic usb_strap,
    input wire logic freq_strap,
    input wire logic pull_strap,
    input wire logic rom_link,
    // pins driven by the device
    input wire logic [2:0] prog_io_out,
    input wire logic [2:0] prog_io_oe,
    input wire logic dplus_pullup_ctl_out,
    input wire logic dplus_pullup_ctl_oe,
    input wire logic [15:0] mem_data_out,
    input wire logic [15:0] mem_data_oe,
    // levels seen back by the device
    output logic [2:0] prog_io_in,
    output logic dplus_pullup_ctl_in,
    output logic [15:0] mem_data_in
);
    logic [2:0] strap;
    logic [15:0] pins;
    // line zero's strap is tied low; the line rises only when the device drives it
    assign strap = {usb_strap, freq_strap, 1'b0};
    // a released line falls back to its strap resistor
    assign prog_io_in = (prog_io_oe & prog_io_out) | (~prog_io_oe & strap);
    assign dplus_pullup_ctl_in =
        dplus_pullup_ctl_oe ? dplus_pullup_ctl_out : pull_strap;
    // undriven data lines sit at their pull-downs
    assign pins = mem_data_oe & mem_data_out;
    // the board link copies line 9 onto line 10
    always_comb begin
        mem_data_in = pins;
        if (rom_link) begin
            mem_data_in[10] = pins[9];
        end
    end
endmodule : bsc_board_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb import bsc_pkg::*; ;
    // ==========================================
    // signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0] prog_io_in, prog_io_out, prog_io_oe;
    logic ext_regulator_enable_in, ext_regulator_enable_out;
    logic ext_regulator_enable_oe, rerr;
    logic dplus_pullup_ctl_in, dplus_pullup_ctl_out, dplus_pullup_ctl_oe;
    logic radio_tx, txrx_dir, wake_from_host, wake_to_host;
    logic stored_config_valid;
    logic [5:0] stored_config_mhz, ref_mhz;
    logic [18:0] mc_addr, mem_addr;
    logic [15:0] mc_dout, mc_din, mem_data_in, mem_data_out, mem_data_oe;
    logic mc_doe, mc_cs, mc_rd, mc_wr;
    logic mem_select_low, mem_read_low, mem_write_low;
    logic usb_transport, rom_boot, config_done;
    logic usb_strap, freq_strap, pull_strap, rom_link;
    int err_count, n_checks;

    bsc_boot_config bsc_boot_config_i (.*);
    bsc_board_model bsc_board_model_i (.*);
    // regulator pin is pulled low on the board; it reads high only while the device drives it high
    assign ext_regulator_enable_in =
        ext_regulator_enable_oe & ext_regulator_enable_out;

    // free-running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // straps are set up before reset and held across its release
    task automatic boot(input logic u, f, p, v, input logic [5:0] m,
                        input logic l);
        int n;
        usb_strap <= u;
        freq_strap <= f;
        pull_strap <= p;
        stored_config_valid <= v;
        stored_config_mhz <= m;
        rom_link <= l;
        presetn <= 1'b0;
        step(2);
        chk("dir in reset", txrx_dir, 1);
        chk("select in reset", mem_select_low, 1);
        presetn <= 1'b1;
        n = 0;
        do begin
            step(1);
            n++;
        end while (config_done !== 1'b1 && n < 50);
        if (config_done !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask : boot

    task automatic strap_case(input logic u, f, p, v,
                              input logic [5:0] m, e);
        boot(u, f, p, v, m, 1'b0);
        chk("transport", usb_transport, u);
        chk("ref_mhz", ref_mhz, e);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status ref", rdat[13:8], e);
        chk("status usb", rdat[0], u);
    endtask : strap_case

    // ==========================================
    // scenarios
    task automatic t_straps;
        strap_case(0, 0, 0, 1, 6'h13, MHZ_13);
        strap_case(0, 0, 1, 1, 6'h13, MHZ_26);
        strap_case(0, 1, 0, 1, 6'h13, 6'h13);
        strap_case(0, 1, 1, 0, 6'h13, MHZ_32);
        strap_case(1, 0, 0, 1, 6'h13, MHZ_32);
        strap_case(1, 1, 1, 1, 6'h13, MHZ_32);
        // later pin activity must not move the selection
        usb_strap <= 1'b0;
        stored_config_mhz <= 6'h0D;
        step(4);
        chk("held usb", usb_transport, 1);
        chk("held ref", ref_mhz, MHZ_32);
        $display("done straps");
    endtask : t_straps

    task automatic t_regs;
        logic [31:0] st;
        boot(0, 0, 0, 0, 6'h00, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reg reset", rdat, 0);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", rerr, 1);
        chk("unmapped data", rdat, 0);
        apb(1'b0, OFS_STATUS, 32'h0);
        st = rdat;
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status read only", rdat, st);
        $display("done regs");
    endtask : t_regs

    task automatic t_radio;
        radio_tx <= 1'b1;
        step(3);
        chk("dir tx", txrx_dir, 0);
        radio_tx <= 1'b0;
        step(3);
        chk("dir rx", txrx_dir, 1);
        apb(1'b1, OFS_CTRL, 32'h1);
        radio_tx <= 1'b1;
        step(3);
        chk("dir swapped", txrx_dir, 1);
        $display("done radio");
    endtask : t_radio

    task automatic t_regulator;
        apb(1'b1, OFS_IO_OUT, 32'h107);
        apb(1'b1, OFS_IO_OE, 32'h107);
        step(2);
        chk("reg io out", ext_regulator_enable_out, 1);
        chk("reg io oe", ext_regulator_enable_oe, 1);
        // strap pins now driven high: the held selection must not move
        chk("io out", prog_io_out, 3'h7);
        chk("io oe", prog_io_oe, 3'h7);
        chk("usb held", usb_transport, 0);
        chk("freq held", ref_mhz, MHZ_13);
        apb(1'b1, OFS_IO_OUT, 32'h0);
        step(2);
        chk("reg io low", ext_regulator_enable_out, 0);
        apb(1'b1, OFS_CTRL, 32'hA);
        step(2);
        chk("reg on high", ext_regulator_enable_out, 1);
        apb(1'b1, OFS_CTRL, 32'hE);
        step(2);
        chk("reg on low", ext_regulator_enable_out, 0);
        $display("done regulator");
    endtask : t_regulator

    task automatic t_wake;
        apb(1'b1, OFS_CTRL, 32'h30);
        wake_from_host <= 1'b1;
        step(3);
        chk("pullup out", dplus_pullup_ctl_out, 1);
        chk("pullup oe", dplus_pullup_ctl_oe, 1);
        chk("wake out", wake_to_host, 1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("wake in", rdat[ST_WAKE_IN], 1);
        $display("done wake");
    endtask : t_wake

    task automatic t_flash;
        chk("flash boot", rom_boot, 0);
        mc_cs <= 1'b1;
        mc_addr <= 19'h5A5A5;
        step(2);
        chk("select low", mem_select_low, 0);
        chk("addr", mem_addr, 19'h5A5A5);
        mc_rd <= 1'b1;
        step(2);
        chk("read low", mem_read_low, 0);
        mc_rd <= 1'b0;
        mc_wr <= 1'b1;
        step(2);
        chk("write low", mem_write_low, 0);
        chk("read idle", mem_read_low, 1);
        mc_wr <= 1'b0;
        mc_cs <= 1'b0;
        step(2);
        chk("select idle", mem_select_low, 1);
        chk("write idle", mem_write_low, 1);
        $display("done flash");
    endtask : t_flash

    task automatic t_rom;
        boot(0, 0, 1, 0, 6'h00, 1'b1);
        chk("rom boot", rom_boot, 1);
        mc_cs <= 1'b1;
        mc_rd <= 1'b1;
        step(2);
        chk("rom select", mem_select_low, 1);
        chk("rom read", mem_read_low, 1);
        mc_cs <= 1'b0;
        mc_rd <= 1'b0;
        // each eeprom pin differs from what the flash path would show
        apb(1'b1, OFS_EEPROM, 32'h1);
        apb(1'b1, OFS_IO_OUT, 32'h10);
        apb(1'b1, OFS_IO_OE, 32'h10);
        step(2);
        chk("eeprom pins", mem_addr[17:16], 2'b10);
        chk("eeprom wp", mem_write_low, 0);
        chk("d4 out", mem_data_out[4], 1);
        chk("d4 oe", mem_data_oe[4], 1);
        chk("d4 back", mc_din, 16'h0010);
        apb(1'b0, OFS_IO_IN, 32'h0);
        chk("io in", rdat, 32'h10);
        $display("done rom");
    endtask : t_rom

    // ==========================================
    // main sequence, all inputs defined at time zero
    initial begin
        err_count = 0;
        n_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {radio_tx, wake_from_host, stored_config_valid} = '0;
        {stored_config_mhz, mc_addr, mc_dout, mc_doe} = '0;
        {mc_cs, mc_rd, mc_wr} = '0;
        {usb_strap, freq_strap, pull_strap, rom_link} = '0;
        step(2);
        t_straps();
        t_regs();
        t_radio();
        t_regulator();
        t_wake();
        t_flash();
        t_rom();
        wrap_up();
    end
endmodule : tb
